// File: charger_cfg_pkg.sv
// Purpose: constants and types for the charger configuration register bank
// Assumes: AHB-Lite slave, 32-bit data, one register per aligned word
// Notes: byte address of a register is four times its index
`default_nettype none
package charger_cfg_pkg;
  // ---------------------------------------------------------------
  // register indices and address width
  // ---------------------------------------------------------------
  localparam logic [7:0] kick_unlock_idx = 8'hbd;
  localparam logic [7:0] thermal_cfg_idx = 8'hbe;
  localparam logic [7:0] ilim_cfg_idx = 8'hc0;
  localparam logic [7:0] irq_status_idx = 8'hc8;
  localparam logic [7:0] irq_mask_idx = 8'hc9;
  localparam logic [7:0] live_status_idx = 8'hca;
  localparam int addr_w = 12;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int kick_lsb = 0;
  localparam int unlock_lsb = 2;
  localparam int setpoint_lsb = 5;
  localparam int evt_kick = 0;
  localparam int evt_fold = 1;
  localparam int evt_locked_wr = 2;
  localparam int evt_n = 3;
  // ---------------------------------------------------------------
  // field values and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] kick_code = 2'h1;
  localparam logic [1:0] unlock_code = 2'h3;
  localparam logic [7:0] kick_unlock_rst = 8'h00;
  localparam logic [7:0] kick_unlock_wmask = 8'h0f;
  localparam logic [7:0] thermal_cfg_rst = 8'h40;
  localparam logic [7:0] ilim_cfg_rst = 8'h0f;
  localparam logic [7:0] ilim_cfg_wmask = 8'h7f;
  localparam logic [evt_n-1:0] irq_mask_rst = 3'h0;
  // ---------------------------------------------------------------
  // decode figures
  // ---------------------------------------------------------------
  localparam logic [7:0] setpoint_base_degc = 8'h55;
  localparam logic [7:0] setpoint_step_degc = 8'h0f;
  localparam logic [11:0] ilim_floor_ma = 12'h064;
  localparam logic [11:0] ilim_ceiling_ma = 12'hfa0;
  localparam logic [6:0] ilim_first_step = 7'h04;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic wdt_restart;
    logic fold_active;
    logic [7:0] setpoint_degc;
    logic [11:0] ilim_ma;
  } charger_ctrl_t;
  typedef struct packed {
    logic sel;
    logic [1:0] trans;
    logic write;
    logic [2:0] size;
    logic [addr_w-1:0] addr;
  } ahb_req_t;
  typedef enum logic {dp_idle, dp_write} dphase_t;
endpackage
`default_nettype wire

// File: charger_config_protect_regs.sv
// Purpose: charger kick/unlock, thermal setpoint and input current cap registers
// Assumes: single AHB-Lite master, zero-wait slave, junction temperature in degC
// Notes: writes to the protected thermal register are dropped while locked
//
// Function
// - a write of 01 to the kick field with the watchdog enabled restarts the watchdog.
// - kick values 00, 10 and 11 leave the watchdog running untouched.
// - writing 11 to the unlock key lets later writes reach protected registers.
// - writing any other value to the unlock key locks the protected registers.
// - the unlock key reads 00 after reset so the protected registers start locked.
// - the thermal configuration register accepts writes only while unlocked.
// - a junction temperature above the setpoint starts current fold-back and sets the fold flag.
// - the seven-bit cap field decodes to 100 mA up to 4.0 A in about 33 mA steps.
// - cap codes 00 to 03 all give 100 mA and stepping starts at 04.
// - the cap field holds 0f after reset.
`timescale 1ns/1ps
`default_nettype none
module charger_config_protect_regs (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // charger side
  input wire logic watchdog_en,
  input wire logic [7:0] junction_temp,
  output charger_cfg_pkg::charger_ctrl_t ctrl,
  output logic thermal_fold_flag,
  output logic irq
);
  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] setpoint_degc_f(input logic [1:0] code);
    logic [7:0] r;
    r = charger_cfg_pkg::setpoint_base_degc;
    for (int i = 0; i < 3; i++) begin
      if (i < int'(code)) begin
        r = r + charger_cfg_pkg::setpoint_step_degc;
      end
    end
    return r;
  endfunction

  // step is 100/3 mA, rounded to the nearest mA
  function automatic logic [11:0] ilim_ma_f(input logic [6:0] code);
    logic [13:0] steps;
    logic [13:0] ma;
    steps = 14'(code) - 14'(charger_cfg_pkg::ilim_first_step) + 14'h0001;
    ma = 14'(charger_cfg_pkg::ilim_floor_ma) + 14'((steps * 14'h0064 + 14'h0001) / 14'h0003);
    if (code < charger_cfg_pkg::ilim_first_step) begin
      ilim_ma_f = charger_cfg_pkg::ilim_floor_ma;
    end else if (ma > 14'(charger_cfg_pkg::ilim_ceiling_ma)) begin
      ilim_ma_f = charger_cfg_pkg::ilim_ceiling_ma;
    end else begin
      ilim_ma_f = ma[11:0];
    end
  endfunction

  function automatic logic [charger_cfg_pkg::addr_w-1:0] byte_addr_f(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  charger_cfg_pkg::ahb_req_t req;
  charger_cfg_pkg::dphase_t dphase_r;
  logic [charger_cfg_pkg::addr_w-1:0] waddr_r;
  logic [1:0] kick_r;
  logic [1:0] unlock_key_r;
  logic [7:0] thermal_cfg_r;
  logic [6:0] ilim_code_r;
  logic [charger_cfg_pkg::evt_n-1:0] irq_status_r;
  logic [charger_cfg_pkg::evt_n-1:0] irq_mask_r;
  logic [charger_cfg_pkg::evt_n-1:0] evt_nxt;
  logic fold_nxt;
  logic addr_ok;
  logic wr_en;
  logic unlocked;
  logic [31:0] rd_nxt;
  logic kick_wr;
  logic thermal_wr;
  logic ilim_wr;
  logic status_wr;
  logic mask_wr;
  logic kick_hit;
  logic wdt_restart_r;
  logic fold_active_r;
  logic [7:0] setpoint_r;
  logic [11:0] ilim_ma_r;

  assign req = '{sel: hsel, trans: htrans, write: hwrite, size: hsize,
                 addr: haddr[charger_cfg_pkg::addr_w-1:0]};
  // nonseq or seq, with the bus free
  assign addr_ok = req.sel && req.trans[1] && hready;
  assign wr_en = (dphase_r == charger_cfg_pkg::dp_write);
  assign unlocked = (unlock_key_r == charger_cfg_pkg::unlock_code);
  assign fold_nxt = junction_temp >
    setpoint_degc_f(thermal_cfg_r[charger_cfg_pkg::setpoint_lsb +: 2]);

  // ---------------------------------------------------------------
  // write strobes, one per writable register, all in the data phase
  // ---------------------------------------------------------------
  assign kick_wr = wr_en && (waddr_r == byte_addr_f(charger_cfg_pkg::kick_unlock_idx));
  assign thermal_wr = wr_en && (waddr_r == byte_addr_f(charger_cfg_pkg::thermal_cfg_idx));
  assign ilim_wr = wr_en && (waddr_r == byte_addr_f(charger_cfg_pkg::ilim_cfg_idx));
  assign status_wr = wr_en && (waddr_r == byte_addr_f(charger_cfg_pkg::irq_status_idx));
  assign mask_wr = wr_en && (waddr_r == byte_addr_f(charger_cfg_pkg::irq_mask_idx));
  // kick field stored either way; only 01 with the watchdog on restarts it
  assign kick_hit = kick_wr && watchdog_en &&
    (hwdata[charger_cfg_pkg::kick_lsb +: 2] == charger_cfg_pkg::kick_code);
  // outputs stay flop bits, only regrouped into the struct
  assign ctrl = '{wdt_restart: wdt_restart_r, fold_active: fold_active_r,
                  setpoint_degc: setpoint_r, ilim_ma: ilim_ma_r};

  // ---------------------------------------------------------------
  // bus phases
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dphase_r <= charger_cfg_pkg::dp_idle;
      waddr_r <= '0;
    end else begin
      if (addr_ok && req.write) begin
        dphase_r <= charger_cfg_pkg::dp_write;
        waddr_r <= req.addr;
      end else begin
        dphase_r <= charger_cfg_pkg::dp_idle;
      end
    end
  end

  // ready from the first clock after reset, never errors, even on locked or unmapped writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (req.addr)
      byte_addr_f(charger_cfg_pkg::kick_unlock_idx): begin
        rd_nxt[3:0] = {unlock_key_r, kick_r};
      end
      byte_addr_f(charger_cfg_pkg::thermal_cfg_idx): begin
        rd_nxt[7:0] = thermal_cfg_r;
      end
      byte_addr_f(charger_cfg_pkg::ilim_cfg_idx): begin
        rd_nxt[6:0] = ilim_code_r;
      end
      byte_addr_f(charger_cfg_pkg::irq_status_idx): begin
        rd_nxt[charger_cfg_pkg::evt_n-1:0] = irq_status_r;
      end
      byte_addr_f(charger_cfg_pkg::irq_mask_idx): begin
        rd_nxt[charger_cfg_pkg::evt_n-1:0] = irq_mask_r;
      end
      byte_addr_f(charger_cfg_pkg::live_status_idx): begin
        rd_nxt[1:0] = {unlocked, thermal_fold_flag};
      end
      default: begin
        rd_nxt = 32'h0000_0000;
      end
    endcase
  end

  // data is ready for the data phase that follows the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !req.write) begin
      hrdata <= rd_nxt;
    end
  end

  // ---------------------------------------------------------------
  // kick and unlock register
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      kick_r <= charger_cfg_pkg::kick_unlock_rst[1:0];
      unlock_key_r <= charger_cfg_pkg::kick_unlock_rst[3:2];
    end else if (kick_wr) begin
      // key kept as written, so a read shows the lock state
      kick_r <= hwdata[charger_cfg_pkg::kick_lsb +: 2];
      unlock_key_r <= hwdata[charger_cfg_pkg::unlock_lsb +: 2];
    end
  end

  // ---------------------------------------------------------------
  // protected thermal register and open cap register
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      thermal_cfg_r <= charger_cfg_pkg::thermal_cfg_rst;
    end else if (thermal_wr && unlocked) begin
      // locked writes vanish here; status bit 2 is their only trace
      thermal_cfg_r <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ilim_code_r <= charger_cfg_pkg::ilim_cfg_rst[6:0];
    end else if (ilim_wr) begin
      // open register: the cap is never locked
      ilim_code_r <= hwdata[6:0];
    end
  end

  // ---------------------------------------------------------------
  // charger controls
  // ---------------------------------------------------------------
  // restart only on a 01 kick while enabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_restart_r <= 1'b0;
    end else begin
      wdt_restart_r <= kick_hit;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fold_active_r <= 1'b0;
      thermal_fold_flag <= 1'b0;
    end else begin
      fold_active_r <= fold_nxt;
      thermal_fold_flag <= fold_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      setpoint_r <=
        setpoint_degc_f(charger_cfg_pkg::thermal_cfg_rst[charger_cfg_pkg::setpoint_lsb +: 2]);
      ilim_ma_r <= ilim_ma_f(charger_cfg_pkg::ilim_cfg_rst[6:0]);
    end else begin
      setpoint_r <= setpoint_degc_f(thermal_cfg_r[charger_cfg_pkg::setpoint_lsb +: 2]);
      ilim_ma_r <= ilim_ma_f(ilim_code_r);
    end
  end

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  always_comb begin
    evt_nxt = '0;
    evt_nxt[charger_cfg_pkg::evt_kick] = kick_hit;
    // rising edge only, a steady overheat sets it once
    evt_nxt[charger_cfg_pkg::evt_fold] = fold_nxt && !thermal_fold_flag;
    evt_nxt[charger_cfg_pkg::evt_locked_wr] = thermal_wr && !unlocked;
  end

  // a new event beats a same-cycle write-one-to-clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_r <= '0;
    end else if (status_wr) begin
      irq_status_r <= (irq_status_r & ~hwdata[charger_cfg_pkg::evt_n-1:0]) | evt_nxt;
    end else begin
      irq_status_r <= irq_status_r | evt_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_r <= charger_cfg_pkg::irq_mask_rst;
    end else if (mask_wr) begin
      irq_mask_r <= hwdata[charger_cfg_pkg::evt_n-1:0];
    end
  end

  // one cycle behind the status bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_r & irq_mask_r);
    end
  end
endmodule // charger_config_protect_regs
`default_nettype wire

// File: charger_regs_sva.sv
// Purpose: bus and charger-side checks for the charger register bank
// Assumes: one clock, zero-wait slave
// Notes: sees only the top module's ports
`timescale 1ns/1ps
`default_nettype none
module charger_regs_sva (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // charger side
  input wire logic watchdog_en,
  input wire logic [7:0] junction_temp,
  input wire charger_cfg_pkg::charger_ctrl_t ctrl,
  input wire logic thermal_fold_flag
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence take_s;
    hsel && htrans[1] && hready;
  endsequence
  sequence kick_wr_s;
    take_s ##0 (hwrite && haddr[11:0] == 12'h2f4) ##1 (hwdata[1:0] == 2'h1 && watchdog_en);
  endsequence
  bus_okay_a: assert property (!hresp) else $error("error response seen");
  bus_ready_a: assert property ($past(hresetn) |-> hreadyout) else $error("wait state seen");
  kick_pulse_a: assert property (kick_wr_s |=> ctrl.wdt_restart) else $error("no restart");
  kick_only_a: assert property (ctrl.wdt_restart |-> $past(hwdata[1:0]) == 2'h1 &&
    $past(watchdog_en)) else $error("stray restart");
  fold_cold_a: assert property (junction_temp <= 8'h55 |=> !thermal_fold_flag)
    else $error("fold below setpoint");
  fold_hot_a: assert property (junction_temp > 8'h82 |=> thermal_fold_flag && ctrl.fold_active)
    else $error("no fold above setpoint");
  unmapped_rd_a: assert property (take_s ##0 (!hwrite && haddr[11:8] == 4'h0) |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  ilim_range_a: assert property (ctrl.ilim_ma >= 12'h064 && ctrl.ilim_ma <= 12'hfa0)
    else $error("cap out of range");
  setpoint_set_a: assert property (ctrl.setpoint_degc inside {8'h55, 8'h64, 8'h73, 8'h82})
    else $error("bad setpoint");
endmodule // charger_regs_sva
bind charger_config_protect_regs charger_regs_sva u_sva (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hwdata, .hreadyout, .hresp, .hrdata, .watchdog_en,
  .junction_temp, .ctrl, .thermal_fold_flag);
`default_nettype wire

// File: charger_config_protect_regs_bench.sv
// Purpose: directed test of the charger register bank
// Assumes: master always leaves one idle cycle between transfers
// Notes: ilim expectations come from the cap table
`timescale 1ns/1ps
`default_nettype none
module charger_config_protect_regs_bench;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, watchdog_en, thermal_fold_flag, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] junction_temp;
  charger_cfg_pkg::charger_ctrl_t ctrl;
  int fail_count, cmp_count, n;
  logic [6:0] code_tab [9] = '{7'h00, 7'h03, 7'h04, 7'h05, 7'h0f, 7'h23, 7'h66, 7'h78, 7'h7f};
  logic [11:0] ma_tab [9] = '{12'h064, 12'h064, 12'h085, 12'h0a7, 12'h1f4, 12'h48f, 12'hd48,
    12'hfa0, 12'hfa0};
  charger_config_protect_regs u_charger_config_protect_regs (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata, .hreadyout, .hresp, .hrdata,
    .watchdog_en, .junction_temp, .ctrl, .thermal_fold_flag, .irq);
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(rd, e);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
    hwdata = 32'h0; watchdog_en = 1'b0; junction_temp = 8'h19;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(32'h2f4, 32'h00);
    rchk(32'h2f8, 32'h40);
    rchk(32'h300, 32'h0f);
    chk({20'h0, ctrl.ilim_ma}, 32'h1f4);
    chk({24'h0, ctrl.setpoint_degc}, 32'h73);
    xfer(32'h2f8, 1'b1, 32'h00);
    rchk(32'h2f8, 32'h40);
    xfer(32'h2f4, 1'b1, 32'h0c);
    for (int i = 0; i < 4; i++) begin
      xfer(32'h2f8, 1'b1, 32'(i << 5));
      rchk(32'h2f8, 32'(i << 5));
      chk({24'h0, ctrl.setpoint_degc}, 32'(85 + 15 * i));
    end
    // every non-unlock key value must lock again
    for (int k = 0; k < 3; k++) begin
      xfer(32'h2f4, 1'b1, 32'h0c);
      xfer(32'h2f4, 1'b1, 32'(k << 2));
      xfer(32'h2f8, 1'b1, 32'h20);
      chk({31'h0, hresp}, 32'h0);
      rchk(32'h2f8, 32'h60);
    end
    watchdog_en <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      if (k == 4) watchdog_en <= 1'b0;
      xfer(32'h2f4, 1'b1, (k == 4) ? 32'h1 : 32'(k));
      n = 0;
      repeat (3) @(posedge hclk) n += int'(ctrl.wdt_restart === 1'b1);
      chk(32'(n), (k == 1) ? 32'h1 : 32'h0);
    end
    for (int i = 0; i < 9; i++) begin
      xfer(32'h300, 1'b1, {25'h0, code_tab[i]});
      rchk(32'h300, {25'h0, code_tab[i]});
      @(posedge hclk);
      chk({20'h0, ctrl.ilim_ma}, {20'h0, ma_tab[i]});
    end
    xfer(32'h320, 1'b1, 32'h7);
    junction_temp <= 8'h82;
    repeat (3) @(posedge hclk);
    chk({31'h0, thermal_fold_flag}, 32'h0);
    xfer(32'h324, 1'b1, 32'h2);
    junction_temp <= 8'h83;
    repeat (3) @(posedge hclk);
    chk({30'h0, thermal_fold_flag, irq}, 32'h3);
    rchk(32'h320, 32'h2);
    junction_temp <= 8'h19;
    xfer(32'h320, 1'b1, 32'h7);
    repeat (2) @(posedge hclk);
    chk({30'h0, thermal_fold_flag, irq}, 32'h0);
    xfer(32'h324, 1'b1, 32'h0);
    junction_temp <= 8'h90;
    repeat (3) @(posedge hclk);
    chk({30'h0, thermal_fold_flag, irq}, 32'h2);
    rchk(32'h328, 32'h1);
    rchk(32'h000, 32'h0);
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge hclk);
    fail_count++;
    give_verdict();
  end
endmodule // charger_config_protect_regs_bench
`default_nettype wire
